// ==== src/stall_pkg.sv ====
// Package of constants and types for the stall prevention supervisor.
`default_nettype none
package stall_pkg;
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned FLAG_HOLD_MS    = 100;
    localparam int unsigned FLAG_HOLD_CYC   = FLAG_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned TENTH_S_CYC     = CLK_HZ / 10;
    localparam int unsigned COLLAPSE_S      = 3;
    localparam int unsigned COLLAPSE_CYC    = COLLAPSE_S * CLK_HZ;
    localparam logic [15:0] COLLAPSE_RPM    = 16'h000f;
    localparam logic [15:0] NO_STALL_RPM    = 16'h012c;
    localparam logic [15:0] SETTING_OFF     = 16'h270f;
    localparam logic [15:0] DELAY_MAX_TENTH = 16'h00fa;
    localparam logic [15:0] LEVEL_FULL      = 16'h03e8;
    localparam logic [15:0] BOOST_MAX       = 16'h05dc;
    localparam logic [7:0]  PHASE_POWER     = 8'h64;
    localparam logic [7:0]  PHASE_REGEN     = 8'h65;
    localparam int unsigned PH_ACC_BIT      = 1;
    localparam int unsigned PH_CONST_BIT    = 2;
    localparam int unsigned PH_DEC_BIT      = 3;
    localparam int unsigned PH_STOP_BIT     = 4;
    localparam logic [7:0]  OUT_FUNC_POS    = 8'h03;
    localparam logic [7:0]  OUT_FUNC_NEG    = 8'h67;
    localparam logic [7:0]  IN_FUNC_SECOND  = 8'h03;
    localparam logic [1:0]  REG_PSEL_R      = 2'h0;
    localparam logic [1:0]  REG_PSEL_HI     = 2'h1;
    localparam logic [7:0]  ADDR_LEVELS     = 8'h00;
    localparam logic [7:0]  ADDR_PHASE      = 8'h04;
    localparam logic [7:0]  ADDR_DELAY      = 8'h08;
    localparam logic [7:0]  ADDR_BOOST      = 8'h0c;
    localparam logic [7:0]  ADDR_TERM       = 8'h10;
    localparam logic [7:0]  ADDR_STATUS     = 8'h14;
    localparam logic [7:0]  ADDR_CTRL       = 8'h18;
    localparam logic [15:0] RST_PRIMARY     = 16'h05dc;
    localparam logic [15:0] RST_SECOND      = 16'h270f;
    localparam logic [7:0]  RST_PHASE       = 8'h00;
    localparam logic [15:0] RST_DELAY       = 16'h0000;
    localparam logic [15:0] RST_BOOST       = 16'h270f;
    localparam logic [7:0]  RST_OUT_FUNC    = 8'h03;
    localparam logic [7:0]  RST_IN_FUNC     = 8'h03;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_STOP  = 3'b010,
        ST_FAULT = 3'b100
    } run_state_t;
    typedef enum logic [2:0] {
        MV_HOLD  = 3'b001,
        MV_DECEL = 3'b010,
        MV_ACCEL = 3'b100
    } speed_cmd_t;
endpackage
`default_nettype wire

// ==== src/stall_prevention_supervisor.sv ====
// Stall prevention supervisor with APB configuration registers.
// Summary of operation
// - Stall flag, once raised by stall action, holds at least 100 ms.
// - Flag drops when current falls to or below the active level.
// - Delay 0 immediate, 0.1 to 25 s delayed, 9999 never flags.
// - Regeneration avoidance or overvoltage stall also drive the flag.
// - Output terminal code 3 gives flag, code 103 gives it inverted.
// - Speed held at 15 r/min by stall for 3 s trips fault, cuts power.
// - Second function select swaps in the second stall level.
// - Input terminal code 3 makes it the second function select.
// - Second function select also enables every other second-set function.
// - Phase select 16 to 31 stops operation on flag; below continues.
// - All three phases disabled means no stall action and no speed fault; regen avoidance or overvoltage still flag.
// - Values 100 and 101 confine stall to power or regeneration.
// - Stop on flag reports stopped-by-stall fault and halts.
// - Boost caps torque below 10 % speed, 0 to 150 %, 9999 is 100 %.
// - Below 10 % speed the primary level comparison is disabled.
// - Stall decelerates in accel or constant, accelerates in decel.
// - Stall action never operates at or below 300 r/min.
// - Second level 9999 means primary; a level of 0 disables stall.
`default_nettype none
module stall_prevention_supervisor
    import stall_pkg::*;
#(
    parameter int unsigned HOLD_CYC     = FLAG_HOLD_CYC,
    parameter int unsigned TENTH_CYC    = TENTH_S_CYC,
    parameter int unsigned COLLAPSE_CNT = COLLAPSE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] output_current,
    input  wire logic [15:0] rotation_speed,
    input  wire logic [15:0] rated_speed,
    input  wire logic        accelerating,
    input  wire logic        decelerating,
    input  wire logic        regenerating,
    input  wire logic        regen_avoid_active,
    input  wire logic        overvoltage_stall_active,
    input  wire logic        input_terminal_pin,
    output logic             output_terminal_pin,
    output logic             stall_flag_output,
    output logic             second_function_select,
    output logic [2:0]       speed_command,
    output logic [15:0]      torque_limit,
    output logic             stall_speed_fault,
    output logic             stall_stop_fault,
    output logic             power_output_enable
);
    logic [15:0] primary_stall_level_reg;
    logic [15:0] second_stall_level_reg;
    logic [7:0]  stall_phase_select_reg;
    logic [15:0] stall_flag_delay_reg;
    logic [15:0] low_speed_torque_limit_reg;
    logic [7:0]  output_terminal_function_reg;
    logic [7:0]  input_terminal_function_reg;
    logic        pin_meta_reg;
    logic        pin_sync_reg;
    logic        flag_reg;
    logic [31:0] hold_cnt_reg;
    logic [31:0] tick_cnt_reg;
    logic [15:0] tenth_cnt_reg;
    logic [31:0] collapse_cnt_reg;
    logic [31:0] prdata_next;
    run_state_t  state_reg;
    speed_cmd_t  cmd_next;

    // Only full word writes are decoded, so sub-word strobes are unneeded.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    wire logic apb_wr = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_stall_level_reg      <= RST_PRIMARY;
            second_stall_level_reg       <= RST_SECOND;
            stall_phase_select_reg       <= RST_PHASE;
            stall_flag_delay_reg         <= RST_DELAY;
            low_speed_torque_limit_reg   <= RST_BOOST;
            output_terminal_function_reg <= RST_OUT_FUNC;
            input_terminal_function_reg  <= RST_IN_FUNC;
        end else if (apb_wr) begin
            if (hit(paddr, ADDR_LEVELS)) begin
                primary_stall_level_reg <= pwdata[15:0];
                second_stall_level_reg  <= pwdata[31:16];
            end else if (hit(paddr, ADDR_PHASE)) begin
                stall_phase_select_reg <= pwdata[7:0];
            end else if (hit(paddr, ADDR_DELAY)) begin
                stall_flag_delay_reg <= pwdata[15:0];
            end else if (hit(paddr, ADDR_BOOST)) begin
                low_speed_torque_limit_reg <= pwdata[15:0];
            end else if (hit(paddr, ADDR_TERM)) begin
                output_terminal_function_reg <= pwdata[7:0];
                input_terminal_function_reg  <= pwdata[15:8];
            end
        end
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit(paddr, ADDR_LEVELS)) begin
            prdata_next = {second_stall_level_reg, primary_stall_level_reg};
        end else if (hit(paddr, ADDR_PHASE)) begin
            prdata_next = {24'h000000, stall_phase_select_reg};
        end else if (hit(paddr, ADDR_DELAY)) begin
            prdata_next = {16'h0000, stall_flag_delay_reg};
        end else if (hit(paddr, ADDR_BOOST)) begin
            prdata_next = {16'h0000, low_speed_torque_limit_reg};
        end else if (hit(paddr, ADDR_TERM)) begin
            prdata_next = {16'h0000, input_terminal_function_reg,
                           output_terminal_function_reg};
        end else if (hit(paddr, ADDR_STATUS)) begin
            prdata_next = {26'h0000000, state_reg, stall_speed_fault,
                           stall_flag_output, second_function_select};
        end
    end

    // Read data is registered in the setup cycle so it is stable at access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= input_terminal_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // The same select is exported so other second-set blocks follow it.
    assign second_function_select = pin_sync_reg &&
        (input_terminal_function_reg == IN_FUNC_SECOND);

    wire logic [15:0] active_level = (second_function_select &&
        second_stall_level_reg != SETTING_OFF) ?
        second_stall_level_reg : primary_stall_level_reg;

    wire logic [31:0] speed_x10 = {16'h0000, rotation_speed} * 32'd10;
    wire logic low_speed = speed_x10 < {16'h0000, rated_speed};
    wire logic [7:0] ph = stall_phase_select_reg;
    wire logic by_state = (ph == PHASE_POWER) || (ph == PHASE_REGEN);

    logic phase_ok;
    always_comb begin
        phase_ok = 1'b0;
        if (by_state) begin
            phase_ok = (ph == PHASE_POWER) ? !regenerating
                                           : regenerating;
        end else if (accelerating) begin
            phase_ok = !ph[PH_ACC_BIT];
        end else if (decelerating) begin
            phase_ok = !ph[PH_DEC_BIT];
        end else begin
            phase_ok = !ph[PH_CONST_BIT];
        end
    end

    wire logic over_level = phase_ok && (active_level != 16'h0000) &&
        (output_current > active_level);

    // Low-speed region relies on the torque cap instead of this compare.
    wire logic stall_action = over_level && !low_speed &&
        (rotation_speed > NO_STALL_RPM);

    wire logic flag_cause = stall_action || regen_avoid_active ||
        overvoltage_stall_active;
    wire logic delay_off = stall_flag_delay_reg == SETTING_OFF;
    wire logic delay_done = tenth_cnt_reg >= stall_flag_delay_reg;
    // The hold counts from the rise only, so a long stall still releases
    // the flag as soon as the current is back under the level.
    wire logic flag_set = flag_cause && delay_done && !delay_off;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg  <= 32'h0000_0000;
            tenth_cnt_reg <= 16'h0000;
        end else if (!flag_cause) begin
            tick_cnt_reg  <= 32'h0000_0000;
            tenth_cnt_reg <= 16'h0000;
        end else if (!delay_done) begin
            if (tick_cnt_reg == TENTH_CYC - 1) begin
                tick_cnt_reg  <= 32'h0000_0000;
                tenth_cnt_reg <= tenth_cnt_reg + 16'h0001;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg     <= 1'b0;
            hold_cnt_reg <= 32'h0000_0000;
        end else if (!flag_reg) begin
            if (flag_set) begin
                flag_reg     <= 1'b1;
                hold_cnt_reg <= HOLD_CYC - 1;
            end
        end else if (hold_cnt_reg != 32'h0000_0000) begin
            hold_cnt_reg <= hold_cnt_reg - 32'h0000_0001;
        end else if (!flag_set) begin
            flag_reg <= 1'b0;
        end
    end
    assign stall_flag_output = flag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_terminal_pin <= 1'b0;
        end else if (output_terminal_function_reg == OUT_FUNC_POS) begin
            output_terminal_pin <= flag_reg;
        end else if (output_terminal_function_reg == OUT_FUNC_NEG) begin
            output_terminal_pin <= !flag_reg;
        end else begin
            output_terminal_pin <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            collapse_cnt_reg <= 32'h0000_0000;
        end else if (!over_level || rotation_speed > COLLAPSE_RPM) begin
            // Speed guards are skipped here, else they would hide a collapse.
            collapse_cnt_reg <= 32'h0000_0000;
        end else if (collapse_cnt_reg != COLLAPSE_CNT) begin
            collapse_cnt_reg <= collapse_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (collapse_cnt_reg == COLLAPSE_CNT) begin
                        state_reg <= ST_FAULT;
                    end else if (flag_reg && ph[PH_STOP_BIT] && !by_state) begin
                        state_reg <= ST_STOP;
                    end
                end
                default: state_reg <= state_reg;
            endcase
        end
    end
    assign stall_speed_fault   = state_reg == ST_FAULT;
    assign stall_stop_fault    = state_reg == ST_STOP;
    assign power_output_enable = state_reg == ST_RUN;

    always_comb begin
        cmd_next = MV_HOLD;
        if (stall_action) begin
            cmd_next = decelerating ? MV_ACCEL : MV_DECEL;
        end
    end
    assign speed_command = cmd_next;

    // Above the cap the value is clipped, so a bad write cannot overdrive.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torque_limit <= LEVEL_FULL;
        end else if (low_speed_torque_limit_reg == SETTING_OFF) begin
            torque_limit <= LEVEL_FULL;
        end else if (low_speed_torque_limit_reg > BOOST_MAX) begin
            torque_limit <= BOOST_MAX;
        end else begin
            torque_limit <= low_speed_torque_limit_reg;
        end
    end

    a_flag_hold: assert property
        (@(posedge pclk) disable iff (!presetn)
        $rose(flag_reg) |-> flag_reg [*8]) else $error("flag hold short");
    a_flag_off: assert property
        (@(posedge pclk) disable iff (!presetn)
        delay_off && !flag_reg |=> !flag_reg) else $error("flag not off");
    a_term_pol: assert property
        (@(posedge pclk) disable iff (!presetn)
        output_terminal_function_reg == OUT_FUNC_NEG |=>
        output_terminal_pin == !$past(flag_reg))
        else $error("terminal polarity");
    a_fault_cut: assert property
        (@(posedge pclk) disable iff (!presetn)
        stall_speed_fault |-> !power_output_enable) else $error("no cut");
    a_level_sel: assert property
        (@(posedge pclk) disable iff (!presetn)
        !second_function_select |-> active_level == primary_stall_level_reg)
        else $error("level select");
    a_all_off: assert property
        (@(posedge pclk) disable iff (!presetn)
        !by_state && ph[3:1] == 3'b111 |-> !over_level)
        else $error("stall while disabled");
    a_stop_hold: assert property
        (@(posedge pclk) disable iff (!presetn)
        stall_stop_fault |=> stall_stop_fault) else $error("stop lost");
    a_slow_none: assert property
        (@(posedge pclk) disable iff (!presetn)
        rotation_speed <= NO_STALL_RPM |-> speed_command == MV_HOLD)
        else $error("stall at low rpm");
    a_decel_cmd: assert property
        (@(posedge pclk) disable iff (!presetn)
        stall_action && decelerating |-> speed_command == MV_ACCEL)
        else $error("wrong direction");
endmodule
`default_nettype wire

// ==== verif/motor_stage_model.sv ====
// Behavioural power stage and motor feeding speed and drive phase back.
`default_nettype none
module motor_stage_model
    import stall_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        power_output_enable,
    input  wire logic [15:0] target_speed,
    input  wire logic [2:0]  drive_mode,
    output logic      [15:0] rotation_speed,
    output logic             accelerating,
    output logic             decelerating,
    output logic             regenerating
);
    timeunit 1ns;
    timeprecision 1ps;
    // The shaft speed drops to zero on the next clock once the stage cuts power.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rotation_speed <= 16'h0000;
        end else if (!power_output_enable) begin
            rotation_speed <= 16'h0000;
        end else begin
            rotation_speed <= target_speed;
        end
    end
    assign accelerating = power_output_enable & drive_mode[0];
    assign decelerating = power_output_enable & drive_mode[1];
    assign regenerating = power_output_enable & drive_mode[2];
endmodule
`default_nettype wire

// ==== verif/stall_prevention_supervisor_test.sv ====
// Self-checking bench for the stall prevention supervisor.
`default_nettype none
module stall_prevention_supervisor_test
    import stall_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          HOLD = 20;
    localparam logic [15:0] HI   = 16'h0640;
    localparam logic [15:0] SP   = 16'h03e8;
    typedef struct packed {
        logic [7:0]  ph;
        logic [2:0]  mode;
        logic [1:0]  aux;
        logic [15:0] cur;
        logic [15:0] spd;
        logic        flag;
        logic [2:0]  cmd;
    } row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] output_current, rotation_speed, rated_speed;
    logic [15:0] target_speed, torque_limit;
    logic [2:0]  drive_mode, speed_command;
    logic        accelerating, decelerating, regenerating;
    logic        regen_avoid_active, overvoltage_stall_active;
    logic        input_terminal_pin, output_terminal_pin;
    logic        stall_flag_output, second_function_select;
    logic        stall_speed_fault, stall_stop_fault, power_output_enable;
    int          fails, checks_done;
    row_t        rows [16] = '{
        '{8'h00, 3'h1, 2'h0, HI, SP, 1'b1, MV_DECEL},
        '{8'h00, 3'h0, 2'h0, HI, SP, 1'b1, MV_DECEL},
        '{8'h00, 3'h2, 2'h0, HI, SP, 1'b1, MV_ACCEL},
        '{8'h02, 3'h1, 2'h0, HI, SP, 1'b0, MV_HOLD},
        '{8'h04, 3'h0, 2'h0, HI, SP, 1'b0, MV_HOLD},
        '{8'h08, 3'h2, 2'h0, HI, SP, 1'b0, MV_HOLD},
        '{8'h00, 3'h0, 2'h0, 16'h05dc, SP, 1'b0, MV_HOLD},
        '{8'h00, 3'h0, 2'h0, HI, 16'h012c, 1'b0, MV_HOLD},
        '{8'h00, 3'h0, 2'h0, HI, 16'h0190, 1'b0, MV_HOLD},
        '{8'h64, 3'h0, 2'h0, HI, SP, 1'b1, MV_DECEL},
        '{8'h64, 3'h4, 2'h0, HI, SP, 1'b0, MV_HOLD},
        '{8'h65, 3'h4, 2'h0, HI, SP, 1'b1, MV_DECEL},
        '{8'h0e, 3'h0, 2'h0, HI, SP, 1'b0, MV_HOLD},
        '{8'h1e, 3'h0, 2'h0, HI, SP, 1'b0, MV_HOLD},
        '{8'h00, 3'h0, 2'h1, 16'h0000, SP, 1'b1, MV_HOLD},
        '{8'h00, 3'h0, 2'h2, 16'h0000, SP, 1'b1, MV_HOLD}
    };
    stall_prevention_supervisor #(
        .HOLD_CYC(HOLD), .TENTH_CYC(10), .COLLAPSE_CNT(50)
    ) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .output_current, .rotation_speed,
        .rated_speed, .accelerating, .decelerating, .regenerating,
        .regen_avoid_active, .overvoltage_stall_active, .input_terminal_pin,
        .output_terminal_pin, .stall_flag_output, .second_function_select,
        .speed_command, .torque_limit, .stall_speed_fault, .stall_stop_fault,
        .power_output_enable
    );
    motor_stage_model motor (
        .pclk, .presetn, .power_output_enable, .target_speed, .drive_mode,
        .rotation_speed, .accelerating, .decelerating, .regenerating
    );
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // The request stands until pready is seen high with penable.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("rdata", e, rd_q);
        chkb("pslverr", 1'b0, pslverr);
    endtask
    task automatic bchk(input logic [31:0] w, input logic [15:0] e);
        apb(1'b1, ADDR_BOOST, w);
        go(3);
        chk("torque_limit", {16'h0, e}, {16'h0, torque_limit});
    endtask
    task automatic reset_dut();
        @(posedge pclk);
        presetn <= 1'b0;
        output_current <= 16'h0000;
        go(2);
        presetn <= 1'b1;
        go(1);
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Sized well past the longest sequence so only a real hang trips it.
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        output_current = 16'h0000;
        rated_speed = 16'h1388;
        target_speed = SP;
        drive_mode = 3'h0;
        {regen_avoid_active, overvoltage_stall_active} = 2'h0;
        input_terminal_pin = 1'b0;
        fails = 0;
        checks_done = 0;
        go(16);
        presetn <= 1'b1;
        go(1);
        foreach (rows[i]) begin
            target_speed <= rows[i].spd;
            apb(1'b1, ADDR_PHASE, {24'h0, rows[i].ph});
            output_current <= rows[i].cur;
            drive_mode <= rows[i].mode;
            {overvoltage_stall_active, regen_avoid_active} <= rows[i].aux;
            go(6);
            chkb("flag", rows[i].flag, stall_flag_output);
            chkb("flag2", rows[i].flag, stall_flag_output);
            chkb("terminal", rows[i].flag, output_terminal_pin);
            chk("cmd", {29'h0, rows[i].cmd}, {29'h0, speed_command});
            chkb("power", 1'b1, power_output_enable);
            output_current <= 16'h0000;
            {overvoltage_stall_active, regen_avoid_active} <= 2'h0;
            go(HOLD + 6);
        end
        target_speed <= SP;
        drive_mode <= 3'h0;
        @(posedge pclk);
        presetn <= 1'b0;
        go(2);
        chk("torque_rst", 32'h3e8, {16'h0, torque_limit});
        chkb("flag_rst", 1'b0, stall_flag_output);
        chkb("power_rst", 1'b1, power_output_enable);
        presetn <= 1'b1;
        go(1);
        rchk(ADDR_LEVELS, 32'h270f_05dc);
        rchk(ADDR_PHASE, 32'h0);
        rchk(ADDR_DELAY, 32'h0);
        rchk(ADDR_BOOST, 32'h270f);
        rchk(ADDR_TERM, 32'h0303);
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        rchk(ADDR_STATUS, 32'h8);
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        rchk(8'h1c, 32'h0);
        apb(1'b1, ADDR_TERM, 32'h0305);
        output_current <= HI;
        go(6);
        chkb("term_off", 1'b0, output_terminal_pin);
        apb(1'b1, ADDR_TERM, 32'h0367);
        go(3);
        chkb("term_inv", 1'b0, output_terminal_pin);
        output_current <= 16'h0000;
        go(HOLD + 6);
        chkb("term_inv_idle", 1'b1, output_terminal_pin);
        apb(1'b1, ADDR_TERM, 32'h0303);
        apb(1'b1, ADDR_DELAY, 32'h2);
        output_current <= HI;
        go(12);
        chkb("dly_early", 1'b0, stall_flag_output);
        output_current <= 16'h0000;
        go(2);
        output_current <= HI;
        go(15);
        chkb("dly_restart", 1'b0, stall_flag_output);
        go(15);
        chkb("dly_done", 1'b1, stall_flag_output);
        output_current <= 16'h0000;
        go(HOLD + 6);
        apb(1'b1, ADDR_DELAY, 32'h270f);
        output_current <= HI;
        go(60);
        chkb("dly_never", 1'b0, stall_flag_output);
        output_current <= 16'h0000;
        apb(1'b1, ADDR_DELAY, 32'h0);
        output_current <= HI;
        go(3);
        chkb("dly_zero", 1'b1, stall_flag_output);
        output_current <= 16'h0000;
        go(12);
        chkb("hold", 1'b1, stall_flag_output);
        go(14);
        chkb("drop", 1'b0, stall_flag_output);
        // A low rated speed keeps 300 r/min out of the low-speed region.
        rated_speed <= 16'h0bb8;
        target_speed <= 16'h012c;
        go(2);
        output_current <= HI;
        go(6);
        chkb("slow_rpm", 1'b0, stall_flag_output);
        target_speed <= 16'h012d;
        go(6);
        chkb("slow_edge", 1'b1, stall_flag_output);
        output_current <= 16'h0000;
        target_speed <= SP;
        rated_speed <= 16'h1388;
        go(HOLD + 6);
        apb(1'b1, ADDR_LEVELS, 32'h06a4_05dc);
        input_terminal_pin <= 1'b1;
        go(4);
        chkb("second_sel", 1'b1, second_function_select);
        rchk(ADDR_STATUS, 32'h9);
        output_current <= HI;
        go(6);
        chkb("second_lvl", 1'b0, stall_flag_output);
        input_terminal_pin <= 1'b0;
        go(8);
        chkb("primary_lvl", 1'b1, stall_flag_output);
        output_current <= 16'h0000;
        input_terminal_pin <= 1'b1;
        apb(1'b1, ADDR_TERM, 32'h0503);
        go(4);
        chkb("in_func", 1'b0, second_function_select);
        apb(1'b1, ADDR_TERM, 32'h0303);
        apb(1'b1, ADDR_LEVELS, 32'h270f_05dc);
        go(HOLD + 6);
        output_current <= HI;
        go(6);
        chkb("second_same", 1'b1, stall_flag_output);
        output_current <= 16'h0000;
        apb(1'b1, ADDR_LEVELS, 32'h270f_0000);
        go(HOLD + 6);
        output_current <= HI;
        go(6);
        chkb("level_zero", 1'b0, stall_flag_output);
        output_current <= 16'h0000;
        input_terminal_pin <= 1'b0;
        bchk(32'h0320, 16'h0320);
        bchk(32'h05dc, 16'h05dc);
        bchk(32'h07d0, 16'h05dc);
        bchk(32'h0000, 16'h0000);
        bchk(32'h270f, 16'h03e8);
        reset_dut();
        apb(1'b1, ADDR_PHASE, 32'h10);
        output_current <= HI;
        go(6);
        chkb("stop_fault", 1'b1, stall_stop_fault);
        chkb("stop_power", 1'b0, power_output_enable);
        reset_dut();
        target_speed <= 16'h000f;
        output_current <= HI;
        go(30);
        target_speed <= SP;
        go(3);
        target_speed <= 16'h000f;
        go(35);
        chkb("collapse_early", 1'b0, stall_speed_fault);
        go(25);
        chkb("collapse", 1'b1, stall_speed_fault);
        chkb("collapse_pwr", 1'b0, power_output_enable);
        reset_dut();
        apb(1'b1, ADDR_PHASE, 32'h0e);
        target_speed <= 16'h000f;
        output_current <= HI;
        go(70);
        chkb("collapse_off", 1'b0, stall_speed_fault);
        give_verdict();
    end
endmodule
`default_nettype wire
